// [design/crc_pkg.sv]
// Package of constants and types for the current reference control block
package crc_pkg;

  // SFR addressing
  localparam logic [7:0] CRC_ADDR_SFR      = 8'hb9;
  localparam logic [3:0] CRC_PAGE_CTRL     = 4'h0;
  localparam logic [3:0] CRC_PAGE_CFG      = 4'hf;

  // Control register field positions
  localparam int         CRC_CTRL_DIR_BIT  = 7;
  localparam int         CRC_CTRL_RNG_BIT  = 6;
  localparam int         CRC_CTRL_CNT_HI   = 5;
  localparam int         CRC_CNT_W         = 6;

  // Configuration register field positions
  localparam int         CRC_CFG_EN_BIT    = 7;
  localparam int         CRC_CFG_SEL_W     = 3;
  localparam logic [7:0] CRC_CFG_WR_MASK   = 8'h87;

  // Reset values
  localparam logic [7:0] CRC_CTRL_RST      = 8'h00;
  localparam logic [7:0] CRC_CFG_RST       = 8'h00;

  // Step sizes in microamps, and number of counter channels
  localparam int         CRC_STEP_LOW_UA   = 1;
  localparam int         CRC_STEP_HIGH_UA  = 8;
  localparam int         CRC_CHAN_N        = 6;
  localparam logic [2:0] CRC_SEL_MAX       = 3'h5;
  localparam logic [5:0] CRC_CNT_OFF       = 6'h00;
  localparam logic [1:0] CRC_TRIM_EQUIV    = 2'h2;

  // SFR access carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crc_sfr_req_t;

  // Analog drive word carrier
  typedef struct packed {
    logic       enable;
    logic       sink;
    logic       high_range;
    logic [5:0] count;
    logic       trim_cell;
  } crc_drive_t;

endpackage

// [design/crc_trim_select.sv]
// Trim source selector: picks one counter channel output and gates trim cell
`timescale 1ns/1ps
module crc_trim_select
  import crc_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_nrst,
  input  wire logic [CRC_CHAN_N-1:0] i_chan_sync,
  input  wire logic                  i_enable,
  input  wire logic [2:0]            i_sel,
  output logic                       o_trim_cell
);

  // Channel decode; reserved codes pick nothing
  function automatic logic pick_chan(input logic [CRC_CHAN_N-1:0] ch,
                                     input logic [2:0] sel);
    logic res;
    res = 1'b0;
    if (sel <= CRC_SEL_MAX) begin
      res = ch[sel];
    end
    return res;
  endfunction

  logic cell_nxt;

  // Cell on only while enabled and the chosen channel is high
  always_comb begin
    cell_nxt = i_enable & pick_chan(i_chan_sync, i_sel);
  end

  // Registered gate drive
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_trim_cell <= 1'b0;
    end else begin
      o_trim_cell <= cell_nxt;
    end
  end

  chk_trim_off: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !i_enable |=> !o_trim_cell)
    else $error("trim cell on while trim disabled");

  chk_trim_follow: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_enable && i_sel <= CRC_SEL_MAX)
      |=> o_trim_cell == $past(i_chan_sync[i_sel]))
    else $error("trim cell does not follow selected channel");

endmodule

// [design/crc_current_ref.sv]
// Digital control of the programmable current reference
`timescale 1ns/1ps
module crc_current_ref
  import crc_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_nrst,
  input  wire crc_sfr_req_t          i_sfr,
  output logic [7:0]                 o_sfr_rdata,
  output logic                       o_sfr_hit,
  input  wire logic [CRC_CHAN_N-1:0] i_counter_channel_output,
  output crc_drive_t                 o_drive,
  output logic [9:0]                 o_magnitude_ua
);

  logic [7:0]            current_ref_control_r;
  logic [7:0]            current_ref_trim_config_r;
  logic [CRC_CHAN_N-1:0] chan_meta_r;
  logic [CRC_CHAN_N-1:0] chan_sync_r;
  logic                  trim_cell;
  logic                  sel_ctrl;
  logic                  sel_cfg;
  logic [7:0]            rdata_nxt;
  logic [9:0]            mag_nxt;
  crc_drive_t            drive_nxt;

  // Page-qualified decode of the shared SFR address
  function automatic logic sfr_match(input crc_sfr_req_t r,
                                     input logic [3:0] pg);
    return (r.addr == CRC_ADDR_SFR) && (r.page == pg);
  endfunction

  assign sel_ctrl = sfr_match(i_sfr, CRC_PAGE_CTRL);
  assign sel_cfg  = sfr_match(i_sfr, CRC_PAGE_CFG);
  assign o_sfr_hit = (i_sfr.rd | i_sfr.wr) & (sel_ctrl | sel_cfg);

  // Control register: direction, range and step count
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      current_ref_control_r <= CRC_CTRL_RST;
    end else if (i_sfr.wr && sel_ctrl) begin
      current_ref_control_r <= i_sfr.wdata;
    end
  end

  // Configuration register: unused bits never stored
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      current_ref_trim_config_r <= CRC_CFG_RST;
    end else if (i_sfr.wr && sel_cfg) begin
      current_ref_trim_config_r <= i_sfr.wdata & CRC_CFG_WR_MASK;
    end
  end

  // Read mux, registered; unmapped reads return zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_sfr.rd && sel_ctrl) begin
      rdata_nxt = current_ref_control_r;
    end else if (i_sfr.rd && sel_cfg) begin
      rdata_nxt = current_ref_trim_config_r & CRC_CFG_WR_MASK;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_sfr_rdata <= 8'h00;
    end else begin
      o_sfr_rdata <= rdata_nxt;
    end
  end

  // Counter channel outputs come from another block; two-stage sync
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      chan_meta_r <= '0;
      chan_sync_r <= '0;
    end else begin
      chan_meta_r <= i_counter_channel_output;
      chan_sync_r <= chan_meta_r;
    end
  end

  // Channel pick and trim cell gating
  crc_trim_select u_trim (
    .i_ref_clk   (i_ref_clk),
    .i_nrst      (i_nrst),
    .i_chan_sync (chan_sync_r),
    .i_enable    (current_ref_trim_config_r[CRC_CFG_EN_BIT]),
    .i_sel       (current_ref_trim_config_r[CRC_CFG_SEL_W-1:0]),
    .o_trim_cell (trim_cell)
  );

  // Drive word and nominal magnitude; trim cell adds two LSBs
  always_comb begin
    logic [7:0] eff_steps;
    eff_steps = 8'h00;
    drive_nxt.count      = current_ref_control_r[CRC_CTRL_CNT_HI:0];
    drive_nxt.enable     = drive_nxt.count != CRC_CNT_OFF;
    drive_nxt.sink       = current_ref_control_r[CRC_CTRL_DIR_BIT];
    drive_nxt.high_range = current_ref_control_r[CRC_CTRL_RNG_BIT];
    drive_nxt.trim_cell  = trim_cell & drive_nxt.enable;
    eff_steps = {2'h0, drive_nxt.count}
              + (drive_nxt.trim_cell ? {6'h00, CRC_TRIM_EQUIV} : 8'h00);
    mag_nxt = drive_nxt.high_range
            ? 10'(eff_steps * CRC_STEP_HIGH_UA)
            : 10'(eff_steps * CRC_STEP_LOW_UA);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_drive        <= '0;
      o_magnitude_ua <= 10'h000;
    end else begin
      o_drive        <= drive_nxt;
      o_magnitude_ua <= mag_nxt;
    end
  end

  chk_reset_off: assert property (@(posedge i_ref_clk)
    !i_nrst |=> (current_ref_control_r == 8'h00)
             && (current_ref_trim_config_r == 8'h00))
    else $error("registers not cleared by reset");

  chk_off_zero: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (current_ref_control_r[5:0] == 6'h00) |=> !o_drive.enable
                                           && o_magnitude_ua == 10'h000)
    else $error("reference active with zero count");

  chk_dir_bit: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.wr && sel_ctrl) |=> ##1 o_drive.sink == $past(i_sfr.wdata[7], 2))
    else $error("direction does not follow control bit 7");

  chk_range_mag: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !trim_cell |=> o_magnitude_ua == ($past(current_ref_control_r[6])
      ? 10'($past(current_ref_control_r[5:0]) * 8)
      : 10'($past(current_ref_control_r[5:0]))))
    else $error("magnitude wrong for range and count");

  chk_cfg_unused: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.rd && sel_cfg) |=> o_sfr_rdata[6:3] == 4'h0)
    else $error("unused configuration bits read nonzero");

  chk_page_decode: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.wr && sel_cfg) |=> $stable(current_ref_control_r))
    else $error("control register written on configuration page");

  chk_trim_equiv: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (trim_cell && current_ref_control_r[5:0] == 6'h04
     && !current_ref_control_r[6]) |=> o_magnitude_ua == 10'd6)
    else $error("full trim not equal to two LSBs");

  // Any non-zero count switches the reference on
  chk_en_nonzero: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (current_ref_control_r[5:0] != 6'h00) |=> o_drive.enable)
    else $error("reference off with non-zero count");

  // Count field reaches the drive word one cycle later
  chk_count_copy: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    1'b1 |=> o_drive.count == $past(current_ref_control_r[5:0]))
    else $error("drive count does not follow control register");

  // Range bit reaches the drive word one cycle later
  chk_range_copy: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    1'b1 |=> o_drive.high_range == $past(current_ref_control_r[6]))
    else $error("drive range does not follow control bit 6");

  // Direction bit reaches the drive word one cycle later
  chk_sink_copy: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    1'b1 |=> o_drive.sink == $past(current_ref_control_r[7]))
    else $error("drive direction does not follow control bit 7");

  // Trim cell never runs while the reference is off
  chk_trim_mask: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_drive.trim_cell |-> o_drive.enable)
    else $error("trim cell on while reference off");

  // Gated trim cell reaches the drive word when the reference is on
  chk_trim_pass: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (trim_cell && current_ref_control_r[5:0] != 6'h00)
      |=> o_drive.trim_cell)
    else $error("trim cell not passed to drive word");

  // Trim cell adds two steps in the low range
  chk_trim_add_lo: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (trim_cell && current_ref_control_r[5:0] != 6'h00
     && !current_ref_control_r[6])
      |=> o_magnitude_ua
          == 10'($past(current_ref_control_r[5:0])) + 10'd2)
    else $error("low range trim magnitude wrong");

  // Trim cell adds two steps in the high range
  chk_trim_add_hi: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (trim_cell && current_ref_control_r[5:0] != 6'h00
     && current_ref_control_r[6])
      |=> o_magnitude_ua
          == (10'($past(current_ref_control_r[5:0])) + 10'd2) * 10'd8)
    else $error("high range trim magnitude wrong");

  // Control read returns the stored value one cycle later
  chk_rd_ctrl: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.rd && sel_ctrl)
      |=> o_sfr_rdata == $past(current_ref_control_r))
    else $error("control read data wrong");

  // Configuration read returns the stored value one cycle later
  chk_rd_cfg: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.rd && sel_cfg)
      |=> o_sfr_rdata == $past(current_ref_trim_config_r))
    else $error("configuration read data wrong");

  // Read data returns to zero when no mapped read is taken
  chk_rd_idle: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !(i_sfr.rd && (sel_ctrl || sel_cfg)) |=> o_sfr_rdata == 8'h00)
    else $error("read data not zero without a mapped read");

  // Configuration write keeps only the defined bits
  chk_cfg_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.wr && sel_cfg) |=> current_ref_trim_config_r
      == ($past(i_sfr.wdata) & CRC_CFG_WR_MASK))
    else $error("configuration write stored wrong value");

  // Control write stores the whole byte
  chk_ctrl_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.wr && sel_ctrl)
      |=> current_ref_control_r == $past(i_sfr.wdata))
    else $error("control write stored wrong value");

  // Control page write leaves the configuration alone
  chk_ctrl_page: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.wr && sel_ctrl) |=> $stable(current_ref_trim_config_r))
    else $error("configuration written on control page");

  // Writes elsewhere touch neither register
  chk_foreign_wr: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (i_sfr.wr && !sel_ctrl && !sel_cfg)
      |=> $stable(current_ref_control_r)
          && $stable(current_ref_trim_config_r))
    else $error("register written by a foreign access");

  // Decode flag stays low off our address and pages
  chk_hit_zero: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (!sel_ctrl && !sel_cfg) |-> !o_sfr_hit)
    else $error("decode flag high for a foreign access");

  // Unused configuration bits are never stored
  chk_cfg_bits: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    current_ref_trim_config_r[6:3] == 4'h0)
    else $error("unused configuration bits stored");

  // Reset clears every registered output
  chk_reset_out: assert property (@(posedge i_ref_clk)
    !i_nrst |=> o_drive == '0 && o_magnitude_ua == 10'h000
             && o_sfr_rdata == 8'h00)
    else $error("outputs not cleared by reset");

  cov_write_ctrl: cover property (@(posedge i_ref_clk) i_sfr.wr && sel_ctrl);
  cov_write_cfg:  cover property (@(posedge i_ref_clk) i_sfr.wr && sel_cfg);
  cov_trim_on:    cover property (@(posedge i_ref_clk) o_drive.trim_cell);
  cov_sink_high:  cover property (@(posedge i_ref_clk)
    o_drive.sink && o_drive.high_range && o_drive.enable);
  cov_read_cfg:   cover property (@(posedge i_ref_clk) i_sfr.rd && sel_cfg);

endmodule

// [bench/crc_cpu_model.sv]
// CPU-side SFR master model for the current reference block
`timescale 1ns/1ps
module crc_cpu_model
  import crc_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_sfr_rdata,
  output crc_sfr_req_t    o_sfr
);
  initial o_sfr = '0;

  // One SFR cycle held across the taking edge, then released inverted
  task automatic acc(input logic w, input logic [3:0] p, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge i_ref_clk);
    o_sfr = '{wr: w, rd: !w, page: p, addr: CRC_ADDR_SFR, wdata: d};
    @(negedge i_ref_clk);
    q = i_sfr_rdata;
    o_sfr = '{wr: 1'b0, rd: 1'b0, page: ~p, addr: ~CRC_ADDR_SFR, wdata: ~d};
  endtask

  // Register write and register read
  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, p, d, q);
  endtask
  task automatic rd(input logic [3:0] p, output logic [7:0] q);
    acc(1'b0, p, 8'h00, q);
  endtask
endmodule

// [bench/current_reference_control_test.sv]
// Self-checking bench for the current reference control block
`timescale 1ns/1ps
module current_reference_control_test;
  import crc_pkg::*;
  logic                  ref_clk = 1'b0;
  logic                  nrst;
  crc_sfr_req_t          sfr;
  logic [7:0]            rdata;
  logic                  hit;
  logic [CRC_CHAN_N-1:0] chan;
  crc_drive_t            drive;
  logic [9:0]            mag;
  logic [7:0]            tab [5] = '{8'h45, 8'hbf, 8'h80, 8'h01, 8'h7e};
  int                    bad_count = 0;
  int                    compares = 0;
  int                    cycles = 0;
  logic                  hit_exp;

  crc_current_ref i_crc_current_ref (
    .i_ref_clk               (ref_clk),
    .i_nrst                  (nrst),
    .i_sfr                   (sfr),
    .o_sfr_rdata             (rdata),
    .o_sfr_hit               (hit),
    .i_counter_channel_output(chan),
    .o_drive                 (drive),
    .o_magnitude_ua          (mag)
  );
  crc_cpu_model i_crc_cpu_model (
    .i_ref_clk  (ref_clk),
    .i_sfr_rdata(rdata),
    .o_sfr      (sfr)
  );

  // 50 MHz clock and cycle ceiling
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // Decode flag checked on every bus request
  always @(posedge ref_clk) begin
    hit_exp = (sfr.addr == CRC_ADDR_SFR)
            && (sfr.page == CRC_PAGE_CTRL || sfr.page == CRC_PAGE_CFG);
    if (nrst && (sfr.wr || sfr.rd)) begin
      cmp({19'h00000, hit}, {19'h00000, hit_exp});
    end
  end

  // Compare helpers for register values and the drive word
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] p, input logic [7:0] e);
    logic [7:0] q;
    i_crc_cpu_model.rd(p, q);
    cmp({12'h000, q}, {12'h000, e});
  endtask
  task automatic ochk(input logic [7:0] c, input logic t);
    cmp({drive, mag}, exp_out(c, t));
  endtask

  // Expected drive word and current for a control value and trim level
  function automatic logic [19:0] exp_out(input logic [7:0] c, input logic t);
    logic       on;
    logic [9:0] m;
    on = (c[5:0] != CRC_CNT_OFF);
    m = (10'(c[5:0]) + 10'(2 * (on & t))) *
        (c[6] ? 10'(CRC_STEP_HIGH_UA) : 10'(CRC_STEP_LOW_UA));
    return {on, c[7], c[6], c[5:0], on & t, m};
  endfunction

  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    chan = '0;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    rchk(CRC_PAGE_CTRL, CRC_CTRL_RST);
    rchk(CRC_PAGE_CFG, CRC_CFG_RST);
    ochk(8'h00, 1'b0);
    foreach (tab[k]) begin
      i_crc_cpu_model.wr(CRC_PAGE_CTRL, tab[k]);
      @(negedge ref_clk);
      ochk(tab[k], 1'b0);
      rchk(CRC_PAGE_CTRL, tab[k]);
    end
    // Unused config bits dropped; foreign page ignored
    i_crc_cpu_model.wr(CRC_PAGE_CFG, 8'h7f);
    rchk(CRC_PAGE_CFG, 8'h07);
    i_crc_cpu_model.wr(4'h3, 8'h55);
    rchk(4'h3, 8'h00);
    rchk(CRC_PAGE_CTRL, 8'h7e);
    // Select codes 0 to 5, selected channel low then high
    i_crc_cpu_model.wr(CRC_PAGE_CTRL, 8'h04);
    for (int s = 0; s < CRC_CHAN_N; s++) begin
      i_crc_cpu_model.wr(CRC_PAGE_CFG, 8'h80 | 8'(s));
      chan = ~(6'h01 << s);
      repeat (5) @(negedge ref_clk);
      ochk(8'h04, 1'b0);
      chan = 6'h01 << s;
      repeat (5) @(negedge ref_clk);
      ochk(8'h04, 1'b1);
    end
    // Trim disabled keeps the cell off with the channel high
    i_crc_cpu_model.wr(CRC_PAGE_CFG, 8'h00);
    chan = 6'h3f;
    repeat (5) @(negedge ref_clk);
    ochk(8'h04, 1'b0);
    // Mid-run reset clears both registers
    i_crc_cpu_model.wr(CRC_PAGE_CFG, 8'h81);
    nrst = 1'b0;
    @(negedge ref_clk);
    nrst = 1'b1;
    rchk(CRC_PAGE_CFG, 8'h00);
    rchk(CRC_PAGE_CTRL, 8'h00);
    ochk(8'h00, 1'b0);
    tally_and_finish();
  end
endmodule
